// File: hdl/gpe_pkg.sv
// package: register map, field positions and reset values of the gpio block
package gpe_pkg;

  // **************************************************************
  // widths
  // **************************************************************
  localparam int NUM_PORTS  = 4;
  localparam int PORT_W     = 8;
  localparam int PORT_E_W   = 3;
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // **************************************************************
  // register map, one aligned word per register
  // **************************************************************
  localparam logic [7:0] PORT_B_BASE = 8'h00;
  localparam logic [7:0] PORT_STRIDE = 8'h0C;
  localparam logic [7:0] OFS_LATCH   = 8'h00;
  localparam logic [7:0] OFS_DIR     = 8'h04;
  localparam logic [7:0] OFS_SAMPLE  = 8'h08;

  localparam logic [7:0] ADDR_GPIO_B_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] ADDR_GPIO_B_DIRECTION    = 8'h04;
  localparam logic [7:0] ADDR_GPIO_B_PIN_SAMPLE   = 8'h08;
  localparam logic [7:0] ADDR_GPIO_C_OUTPUT_LATCH = 8'h0C;
  localparam logic [7:0] ADDR_GPIO_C_DIRECTION    = 8'h10;
  localparam logic [7:0] ADDR_GPIO_C_PIN_SAMPLE   = 8'h14;
  localparam logic [7:0] ADDR_GPIO_D_OUTPUT_LATCH = 8'h18;
  localparam logic [7:0] ADDR_GPIO_D_DIRECTION    = 8'h1C;
  localparam logic [7:0] ADDR_GPIO_D_PIN_SAMPLE   = 8'h20;
  localparam logic [7:0] ADDR_GPIO_E_OUTPUT_LATCH = 8'h24;
  localparam logic [7:0] ADDR_GPIO_E_DIRECTION    = 8'h28;
  localparam logic [7:0] ADDR_GPIO_E_PIN_SAMPLE   = 8'h2C;
  localparam logic [7:0] ADDR_GPIO_CONFIG         = 8'h30;
  localparam logic [7:0] ADDR_GPIO_STATUS         = 8'h34;

  // **************************************************************
  // fields and reset values
  // **************************************************************
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] DIR_RESET    = 8'h00;
  localparam logic [1:0] CONFIG_RESET = 2'h0;
  localparam int CFG_PULLUP_DISABLE_BIT = 0;
  localparam int CFG_ANALOG_CH0_DIS_BIT = 1;

  // port e pin roles
  localparam int E_RESET_PIN    = 0;
  localparam int E_XTAL_IN_PIN  = 1;
  localparam int E_XTAL_OUT_PIN = 2;

  typedef enum logic [1:0] {
    GPE_CLK_RC,
    GPE_CLK_CRYSTAL,
    GPE_CLK_LF_CRYSTAL,
    GPE_CLK_EXTERNAL
  } gpe_clk_src_type;

endpackage

// File: hdl/gpe_port.sv
// one gpio port: output latch, direction, pin synchroniser and pin drivers
`timescale 1ns/1ns
module gpe_port
  import gpe_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              wr_latch,
  input  wire logic              wr_dir,
  input  wire logic              wr_toggle,
  input  wire logic [PORT_W-1:0] wdata,
  input  wire logic [PORT_W-1:0] pin_in,
  input  wire logic              pullup_disable,
  input  wire logic [PORT_W-1:0] gpio_block,
  input  wire logic [PORT_W-1:0] input_disable,
  input  wire logic [PORT_W-1:0] read_zero,
  input  wire logic [PORT_W-1:0] value_override_enable,
  input  wire logic [PORT_W-1:0] value_override_value,
  output logic      [PORT_W-1:0] rd_latch,
  output logic      [PORT_W-1:0] rd_dir,
  output logic      [PORT_W-1:0] rd_sample,
  output logic      [PORT_W-1:0] level,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] pullup_en
);

  // unimplemented bits stay zero and ignore writes
  localparam logic [PORT_W-1:0] IMPL = PORT_W'((1 << W) - 1);

  logic [PORT_W-1:0] latch;
  logic [PORT_W-1:0] dir;
  logic [PORT_W-1:0] sync_meta;
  logic [PORT_W-1:0] sync_q;
  logic [PORT_W-1:0] next_latch;
  logic [PORT_W-1:0] next_pin_out;
  logic [PORT_W-1:0] next_pin_oe;
  logic [PORT_W-1:0] next_pullup;

  assign next_latch = wr_latch  ? (wdata & IMPL) :
                      wr_toggle ? (latch ^ (wdata & IMPL)) : latch;

  assign next_pin_out = ((value_override_enable & value_override_value) |
                        (~value_override_enable & latch)) & IMPL;
  assign next_pin_oe  = dir & ~gpio_block & IMPL;
  assign next_pullup  = ~dir & latch & ~gpio_block & IMPL &
                        {PORT_W{~pullup_disable}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch     <= LATCH_RESET;
      dir       <= DIR_RESET;
      pin_out   <= '0;
      pin_oe    <= '0;
      pullup_en <= '0;
    end else begin
      latch     <= next_latch;
      if (wr_dir) begin
        dir <= wdata & IMPL;
      end
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      pullup_en <= next_pullup;
    end
  end

  // no reset: the sample follows the pins, not a reset value
  always_ff @(posedge pclk) begin
    sync_meta <= pin_in;
    sync_q    <= sync_meta;
  end

  assign level     = sync_q & IMPL & ~input_disable;
  assign rd_latch  = latch & ~read_zero;
  assign rd_dir    = dir & ~read_zero;
  assign rd_sample = level & ~read_zero;

endmodule // gpe_port

// File: hdl/gpe_top.sv
// gpio ports b to e with port e alternate-function overrides, apb slave
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns

module gpe_top
  import gpe_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  reset_pin_disable_fuse,
  input  wire gpe_pkg::gpe_clk_src_type clk_source,
  input  wire logic                  timer0_compare_b_output_enable,
  input  wire logic                  timer0_compare_b_output,
  input  wire logic [PORT_W-1:0]     gpio_b_pin_in,
  output logic      [PORT_W-1:0]     gpio_b_pin_out,
  output logic      [PORT_W-1:0]     gpio_b_pin_oe,
  output logic      [PORT_W-1:0]     gpio_b_pullup_en,
  input  wire logic [PORT_W-1:0]     gpio_c_pin_in,
  output logic      [PORT_W-1:0]     gpio_c_pin_out,
  output logic      [PORT_W-1:0]     gpio_c_pin_oe,
  output logic      [PORT_W-1:0]     gpio_c_pullup_en,
  input  wire logic [PORT_W-1:0]     gpio_d_pin_in,
  output logic      [PORT_W-1:0]     gpio_d_pin_out,
  output logic      [PORT_W-1:0]     gpio_d_pin_oe,
  output logic      [PORT_W-1:0]     gpio_d_pullup_en,
  input  wire logic [PORT_E_W-1:0]   gpio_e_pin_in,
  output logic      [PORT_E_W-1:0]   gpio_e_pin_out,
  output logic      [PORT_E_W-1:0]   gpio_e_pin_oe,
  output logic      [PORT_E_W-1:0]   gpio_e_pullup_en,
  output logic                       pin_change_source_24,
  output logic                       pin_change_source_25,
  output logic                       pin_change_source_26,
  output logic                       pin_reset_request
);

  // **************************************************************
  // declarations
  // **************************************************************
  logic                  fuse_q;
  gpe_clk_src_type       clk_src_q;
  logic [1:0]            config_q;
  logic                  pullup_disable;
  logic                  analog_ch0_digital_disable;
  logic                  reset_pin_used;
  logic                  xtal_in_used;
  logic                  xtal_out_used;

  logic                  apb_setup;
  logic                  apb_write;
  logic [7:0]            addr8;
  logic                  hit_config;
  logic                  hit_status;
  logic                  rd_hit;
  logic [7:0]            rd_byte;
  logic [7:0]            config_rd;
  logic [7:0]            status_rd;

  logic [PORT_W-1:0]     pin_in_a   [NUM_PORTS];
  logic [PORT_W-1:0]     block_a    [NUM_PORTS];
  logic [PORT_W-1:0]     in_dis_a   [NUM_PORTS];
  logic [PORT_W-1:0]     zero_a     [NUM_PORTS];
  logic [PORT_W-1:0]     ovr_en_a   [NUM_PORTS];
  logic [PORT_W-1:0]     ovr_val_a  [NUM_PORTS];
  logic [PORT_W-1:0]     rd_lat_a   [NUM_PORTS];
  logic [PORT_W-1:0]     rd_dir_a   [NUM_PORTS];
  logic [PORT_W-1:0]     rd_smp_a   [NUM_PORTS];
  logic [PORT_W-1:0]     level_a    [NUM_PORTS];
  logic [PORT_W-1:0]     out_a      [NUM_PORTS];
  logic [PORT_W-1:0]     oe_a       [NUM_PORTS];
  logic [PORT_W-1:0]     pu_a       [NUM_PORTS];
  logic [PORT_W-1:0]     rd_acc     [NUM_PORTS+1];
  logic                  hit_acc    [NUM_PORTS+1];

  logic [PORT_E_W-1:0]   e_block;
  logic [PORT_E_W-1:0]   e_in_dis;
  logic [PORT_E_W-1:0]   e_zero;
  logic [PORT_E_W-1:0]   e_ovr_en;
  logic [PORT_E_W-1:0]   e_ovr_val;
  logic                  next_reset_request;

  // **************************************************************
  // fuse and clock source straps
  // **************************************************************
  // straps re-sampled every clock, reset value keeps the reset pin live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_q    <= 1'b0;
      clk_src_q <= GPE_CLK_RC;
    end else begin
      fuse_q    <= reset_pin_disable_fuse;
      clk_src_q <= clk_source;
    end
  end

  assign reset_pin_used = ~fuse_q;
  assign xtal_in_used   = (clk_src_q != GPE_CLK_RC);
  assign xtal_out_used  = (clk_src_q == GPE_CLK_CRYSTAL) ||
                          (clk_src_q == GPE_CLK_LF_CRYSTAL);

  assign pullup_disable             = config_q[CFG_PULLUP_DISABLE_BIT];
  assign analog_ch0_digital_disable = config_q[CFG_ANALOG_CH0_DIS_BIT];

  // **************************************************************
  // port e override signals
  // **************************************************************
  always_comb begin
    e_block                 = '0;
    e_block[E_XTAL_OUT_PIN] = xtal_out_used;
    e_block[E_XTAL_IN_PIN]  = xtal_in_used;
    e_block[E_RESET_PIN]    = reset_pin_used;
  end

  always_comb begin
    e_in_dis                 = '0;
    e_in_dis[E_XTAL_OUT_PIN] = analog_ch0_digital_disable |
                               xtal_out_used;
    e_in_dis[E_XTAL_IN_PIN]  = xtal_in_used;
  end

  always_comb begin
    e_zero              = '0;
    e_zero[E_RESET_PIN] = reset_pin_used;
  end

  // compare b drives only once direction bit 1 is set by software
  always_comb begin
    e_ovr_en                = '0;
    e_ovr_val               = '0;
    e_ovr_en[E_XTAL_IN_PIN] = timer0_compare_b_output_enable;
    e_ovr_val[E_XTAL_IN_PIN] = timer0_compare_b_output;
  end

  assign pin_in_a[0] = gpio_b_pin_in;
  assign pin_in_a[1] = gpio_c_pin_in;
  assign pin_in_a[2] = gpio_d_pin_in;
  assign pin_in_a[3] = {{(PORT_W-PORT_E_W){1'b0}}, gpio_e_pin_in};

  // **************************************************************
  // apb decode
  // **************************************************************
  assign apb_setup  = psel & ~penable;
  assign apb_write  = psel & penable & pready & pwrite;
  assign addr8      = paddr[7:0];
  assign hit_config = (addr8 == ADDR_GPIO_CONFIG);
  assign hit_status = (addr8 == ADDR_GPIO_STATUS);

  assign config_rd = {6'h0, config_q};
  assign status_rd = {3'h0, fuse_q, clk_src_q, xtal_out_used,
                      xtal_in_used};

  assign rd_acc[0]  = '0;
  assign hit_acc[0] = 1'b0;

  // **************************************************************
  // ports b, c, d and e
  // **************************************************************
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    localparam int W = (i == NUM_PORTS - 1) ? PORT_E_W : PORT_W;
    localparam logic [7:0] BASE = 8'(PORT_B_BASE + i * PORT_STRIDE);

    logic sel_lat;
    logic sel_dir;
    logic sel_smp;

    assign sel_lat = (addr8 == 8'(BASE + OFS_LATCH));
    assign sel_dir = (addr8 == 8'(BASE + OFS_DIR));
    assign sel_smp = (addr8 == 8'(BASE + OFS_SAMPLE));

    if (i == NUM_PORTS - 1) begin : g_e
      assign block_a[i]   = {{(PORT_W-PORT_E_W){1'b0}}, e_block};
      assign in_dis_a[i]  = {{(PORT_W-PORT_E_W){1'b0}}, e_in_dis};
      assign zero_a[i]    = {{(PORT_W-PORT_E_W){1'b0}}, e_zero};
      assign ovr_en_a[i]  = {{(PORT_W-PORT_E_W){1'b0}}, e_ovr_en};
      assign ovr_val_a[i] = {{(PORT_W-PORT_E_W){1'b0}}, e_ovr_val};
    end else begin : g_bcd
      // their alternate functions live elsewhere
      assign block_a[i]   = '0;
      assign in_dis_a[i]  = '0;
      assign zero_a[i]    = '0;
      assign ovr_en_a[i]  = '0;
      assign ovr_val_a[i] = '0;
    end

    gpe_port #(
      .W (W)
    ) u_port (
      .pclk                  (pclk),
      .presetn               (presetn),
      .wr_latch              (apb_write & sel_lat),
      .wr_dir                (apb_write & sel_dir),
      .wr_toggle             (apb_write & sel_smp),
      .wdata                 (pwdata[PORT_W-1:0]),
      .pin_in                (pin_in_a[i]),
      .pullup_disable        (pullup_disable),
      .gpio_block            (block_a[i]),
      .input_disable         (in_dis_a[i]),
      .read_zero             (zero_a[i]),
      .value_override_enable (ovr_en_a[i]),
      .value_override_value  (ovr_val_a[i]),
      .rd_latch              (rd_lat_a[i]),
      .rd_dir                (rd_dir_a[i]),
      .rd_sample             (rd_smp_a[i]),
      .level                 (level_a[i]),
      .pin_out               (out_a[i]),
      .pin_oe                (oe_a[i]),
      .pullup_en             (pu_a[i])
    );

    assign rd_acc[i+1] = rd_acc[i] |
                         ({PORT_W{sel_lat}} & rd_lat_a[i]) |
                         ({PORT_W{sel_dir}} & rd_dir_a[i]) |
                         ({PORT_W{sel_smp}} & rd_smp_a[i]);
    assign hit_acc[i+1] = hit_acc[i] | sel_lat | sel_dir | sel_smp;
  end

  assign rd_byte = rd_acc[NUM_PORTS] |
                   ({8{hit_config}} & config_rd) |
                   ({8{hit_status}} & status_rd);
  assign rd_hit  = hit_acc[NUM_PORTS] | hit_config | hit_status;

  // **************************************************************
  // apb answer: one access cycle, no wait states
  // **************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~rd_hit;
      prdata  <= apb_setup ? {24'h0, rd_byte} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= CONFIG_RESET;
    end else if (apb_write && hit_config) begin
      config_q <= pwdata[1:0];
    end
  end

  // **************************************************************
  // pin-change sources and reset pin
  // **************************************************************
  // pin low while wired as reset asks the reset circuitry for reset
  assign next_reset_request = reset_pin_used &
                              ~level_a[NUM_PORTS-1][E_RESET_PIN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_source_24 <= 1'b0;
      pin_change_source_25 <= 1'b0;
      pin_change_source_26 <= 1'b0;
      pin_reset_request    <= 1'b0;
    end else begin
      pin_change_source_24 <= level_a[NUM_PORTS-1][0];
      pin_change_source_25 <= level_a[NUM_PORTS-1][1];
      pin_change_source_26 <= level_a[NUM_PORTS-1][2];
      pin_reset_request    <= next_reset_request;
    end
  end

  // **************************************************************
  // pin outputs
  // **************************************************************
  assign gpio_b_pin_out   = out_a[0];
  assign gpio_b_pin_oe    = oe_a[0];
  assign gpio_b_pullup_en = pu_a[0];
  assign gpio_c_pin_out   = out_a[1];
  assign gpio_c_pin_oe    = oe_a[1];
  assign gpio_c_pullup_en = pu_a[1];
  assign gpio_d_pin_out   = out_a[2];
  assign gpio_d_pin_oe    = oe_a[2];
  assign gpio_d_pullup_en = pu_a[2];
  assign gpio_e_pin_out   = out_a[3][PORT_E_W-1:0];
  assign gpio_e_pin_oe    = oe_a[3][PORT_E_W-1:0];
  assign gpio_e_pullup_en = pu_a[3][PORT_E_W-1:0];

endmodule // gpe_top

// File: tb/gpe_board.sv
// board model: resolves each pin from device drive, pull-up and far side
`timescale 1ns/1ns
module gpe_board #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] pullup_en,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_drv,
  output logic      [W-1:0] pin_in
);
  logic [W-1:0] float_pat = '0;
  // an undriven pin wanders, so a stale level never reads back as valid
  always_ff @(posedge pclk) float_pat <= ~float_pat;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
                | (~pin_oe & ~ext_drv & (pullup_en | float_pat));
endmodule // gpe_board

// File: tb/gpe_top_assertions.sv
// concurrent checks on the gpio block ports
`timescale 1ns/1ns
module gpe_checker
  import gpe_pkg::*;
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic [APB_ADDR_W-1:0]    paddr,
  input wire logic [APB_DATA_W-1:0]    prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     reset_pin_disable_fuse,
  input wire gpe_pkg::gpe_clk_src_type clk_source,
  input wire logic                     timer0_compare_b_output_enable,
  input wire logic                     timer0_compare_b_output,
  input wire logic [PORT_W-1:0]        gpio_b_pin_oe,
  input wire logic [PORT_W-1:0]        gpio_b_pullup_en,
  input wire logic [PORT_E_W-1:0]      gpio_e_pin_in,
  input wire logic [PORT_E_W-1:0]      gpio_e_pin_out,
  input wire logic [PORT_E_W-1:0]      gpio_e_pin_oe,
  input wire logic [PORT_E_W-1:0]      gpio_e_pullup_en,
  input wire logic                     pin_change_source_25,
  input wire logic                     pin_reset_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire e_reg = paddr inside {ADDR_GPIO_E_OUTPUT_LATCH,
                ADDR_GPIO_E_DIRECTION, ADDR_GPIO_E_PIN_SAMPLE};
  // straps take one edge, pin outputs one more, hence the extra delay
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_bad_addr: assert property (pready |-> pslverr ==
    (paddr > ADDR_GPIO_STATUS || paddr[1:0] != 2'b00))
    else $error("error flag wrong");
  a_e_upper_zero: assert property (pready && e_reg |-> prdata[31:3] == '0)
    else $error("port e upper bits not zero");
  a_reset_pin_read: assert property (pready && e_reg &&
    !$past(reset_pin_disable_fuse, 2) |-> !prdata[0])
    else $error("reset pin bit reads one");
  a_xtal_out_off: assert property (clk_source inside
    {GPE_CLK_CRYSTAL, GPE_CLK_LF_CRYSTAL} |=> ##1
    !gpio_e_pin_oe[2] && !gpio_e_pullup_en[2])
    else $error("crystal out pin used as gpio");
  a_xtal_in_off: assert property (clk_source != GPE_CLK_RC |=> ##1
    !gpio_e_pin_oe[1] && !gpio_e_pullup_en[1])
    else $error("crystal in pin used as gpio");
  a_cmp_b_drive: assert property (timer0_compare_b_output_enable &&
    clk_source == GPE_CLK_RC && $past(clk_source) == GPE_CLK_RC
    |=> gpio_e_pin_out[1] == $past(timer0_compare_b_output))
    else $error("compare b value not on pin");
  a_fuse_no_reset: assert property (reset_pin_disable_fuse [*3]
    |-> !pin_reset_request)
    else $error("pin reset with fuse programmed");
  a_reset_pin_off: assert property (!reset_pin_disable_fuse |=> ##1
    !gpio_e_pin_oe[0] && !gpio_e_pullup_en[0])
    else $error("reset pin used as gpio");
  a_pin_sync: assert property ($past(presetn) &&
    $past(clk_source, 2) == GPE_CLK_RC |->
    pin_change_source_25 == $past(gpio_e_pin_in[1], 3))
    else $error("pin change level timing wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !presetn |->
    gpio_e_pin_oe == '0 && gpio_b_pin_oe == '0 && !pready)
    else $error("outputs active in reset");
  a_pull_input: assert property ((gpio_b_pullup_en & gpio_b_pin_oe) == '0 &&
    (gpio_e_pullup_en & gpio_e_pin_oe) == '0)
    else $error("pull-up on a driven pin");
endmodule // gpe_checker
bind gpe_top gpe_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .reset_pin_disable_fuse(reset_pin_disable_fuse),
  .clk_source(clk_source),
  .timer0_compare_b_output_enable(timer0_compare_b_output_enable),
  .timer0_compare_b_output(timer0_compare_b_output),
  .gpio_b_pin_oe(gpio_b_pin_oe), .gpio_b_pullup_en(gpio_b_pullup_en),
  .gpio_e_pin_in(gpio_e_pin_in), .gpio_e_pin_out(gpio_e_pin_out),
  .gpio_e_pin_oe(gpio_e_pin_oe), .gpio_e_pullup_en(gpio_e_pullup_en),
  .pin_change_source_25(pin_change_source_25),
  .pin_reset_request(pin_reset_request));

// File: tb/tb.sv
// self-checking bench for the gpio ports block
`timescale 1ns/1ns
module tb;
  import gpe_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, err;
  logic            fuse, cmp_en, cmp_val, pc24, pc25, pc26, rst_req;
  logic [7:0]      paddr, base, lat, dir, m;
  logic [31:0]     pwdata, prdata, rd;
  logic            pready, pslverr;
  gpe_clk_src_type src;
  logic [7:0]      b_in, b_out, b_oe, b_pu, b_ev, b_ed;
  logic [7:0]      c_in, c_out, c_oe, c_pu, d_in, d_out, d_oe, d_pu;
  logic [2:0]      e_in, e_out, e_oe, e_pu, e_ev, e_ed;
  int              errors, comparisons;

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  gpe_top i_gpe_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_disable_fuse(fuse), .clk_source(src),
    .timer0_compare_b_output_enable(cmp_en),
    .timer0_compare_b_output(cmp_val),
    .gpio_b_pin_in(b_in), .gpio_b_pin_out(b_out), .gpio_b_pin_oe(b_oe),
    .gpio_b_pullup_en(b_pu), .gpio_c_pin_in(c_in), .gpio_c_pin_out(c_out),
    .gpio_c_pin_oe(c_oe), .gpio_c_pullup_en(c_pu), .gpio_d_pin_in(d_in),
    .gpio_d_pin_out(d_out), .gpio_d_pin_oe(d_oe), .gpio_d_pullup_en(d_pu),
    .gpio_e_pin_in(e_in), .gpio_e_pin_out(e_out), .gpio_e_pin_oe(e_oe),
    .gpio_e_pullup_en(e_pu), .pin_change_source_24(pc24),
    .pin_change_source_25(pc25), .pin_change_source_26(pc26),
    .pin_reset_request(rst_req));
  gpe_board #(.W(8)) i_gpe_board_b (.pclk(pclk), .pin_out(b_out),
    .pin_oe(b_oe), .pullup_en(b_pu), .ext_val(b_ev), .ext_drv(b_ed),
    .pin_in(b_in));
  gpe_board #(.W(3)) i_gpe_board_e (.pclk(pclk), .pin_out(e_out),
    .pin_oe(e_oe), .pullup_en(e_pu), .ext_val(e_ev), .ext_drv(e_ed),
    .pin_in(e_in));

  // **************************************************************
  // helpers
  // **************************************************************
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("apb answer", 1, 0);
      end_of_test();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h00_0000, v});
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // pins that may drive for a clock source and fuse setting
  function automatic logic [2:0] e_drive_exp(input int s, input logic f);
    return {s != int'(GPE_CLK_CRYSTAL) && s != int'(GPE_CLK_LF_CRYSTAL),
            s == int'(GPE_CLK_RC), f};
  endfunction

  // **************************************************************
  // main sequence
  // **************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fuse, cmp_en, cmp_val} = 3'h4;
    src = GPE_CLK_RC;
    {b_ev, b_ed, c_in, d_in, e_ev, e_ed} = '0;
    void'($urandom(21556));
    tick(6);
    presetn <= 1'b1;
    tick(1);
    chk("b oe after reset", 0, b_oe);
    for (int p = 0; p < NUM_PORTS; p++) begin
      base = PORT_B_BASE + PORT_STRIDE * 8'(p);
      rdc("latch reset", base + OFS_LATCH, 0);
      rdc("dir reset", base + OFS_DIR, 0);
    end
    for (int i = 0; i < 12; i++) begin
      base = PORT_B_BASE + PORT_STRIDE * 8'(i % 4);
      m = (i % 4 == 3) ? 8'h07 : 8'hFF;
      lat = 8'($urandom);
      dir = (i == 0) ? 8'hFF : 8'($urandom);
      wr(base + OFS_LATCH, lat);
      wr(base + OFS_DIR, dir);
      rdc("latch", base + OFS_LATCH, lat & m);
      rdc("dir", base + OFS_DIR, dir & m);
      if (i % 4 == 0) begin
        chk("b out", lat, b_out);
        chk("b oe", dir, b_oe);
        chk("b pull-up", ~dir & lat, b_pu);
        wr(ADDR_GPIO_CONFIG, 8'h01);
        tick(1);
        chk("b pull-up off", 0, b_pu);
        wr(ADDR_GPIO_CONFIG, 8'h00);
      end
      if (i % 4 == 1 || i % 4 == 2) begin
        chk("c/d out", lat, (i % 4 == 1) ? c_out : d_out);
        chk("c/d oe", dir, (i % 4 == 1) ? c_oe : d_oe);
        chk("c/d pull-up", ~dir & lat, (i % 4 == 1) ? c_pu : d_pu);
      end
    end
    wr(ADDR_GPIO_B_DIRECTION, 8'h00);
    wr(ADDR_GPIO_E_DIRECTION, 8'h00);
    b_ed <= 8'hFF;
    e_ed <= 3'h7;
    b_ev <= 8'($urandom);
    e_ev <= 3'($urandom);
    c_in <= 8'($urandom);
    d_in <= 8'($urandom);
    tick(3);
    rdc("b sample", ADDR_GPIO_B_PIN_SAMPLE, b_ev);
    rdc("c sample", ADDR_GPIO_C_PIN_SAMPLE, c_in);
    rdc("d sample", ADDR_GPIO_D_PIN_SAMPLE, d_in);
    rdc("e sample", ADDR_GPIO_E_PIN_SAMPLE, e_ev);
    wr(ADDR_GPIO_B_OUTPUT_LATCH, 8'h0F);
    wr(ADDR_GPIO_B_PIN_SAMPLE, 8'h3C);
    rdc("toggled latch", ADDR_GPIO_B_OUTPUT_LATCH, 8'h33);
    // unmapped place and read-only status
    wr(8'h38, 8'hFF);
    chk("write error", 1, err);
    rdc("unmapped read", 8'h38, 0);
    chk("read error", 1, err);
    wr(ADDR_GPIO_STATUS, 8'hFF);
    chk("status write error", 0, err);
    e_ed <= 3'h0;
    wr(ADDR_GPIO_E_OUTPUT_LATCH, 8'h00);
    wr(ADDR_GPIO_E_DIRECTION, 8'h07);
    for (int s = 0; s < 4; s++) begin
      src <= gpe_clk_src_type'(s);
      tick(3);
      chk("e oe by clock", e_drive_exp(s, 1'b1), e_oe);
    end
    src <= GPE_CLK_RC;
    cmp_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cmp_val <= 1'($urandom);
      tick(3);
      chk("compare b pin", cmp_val, e_out[1]);
    end
    cmp_en <= 1'b0;
    wr(ADDR_GPIO_E_OUTPUT_LATCH, 8'h07);
    tick(1);
    chk("e out from latch", 3'h7, e_out);
    fuse <= 1'b0;
    e_ed <= 3'h1;
    e_ev <= 3'h0;
    tick(6);
    chk("reset pin oe", 0, e_oe[0]);
    chk("pin reset request", 1, rst_req);
    rdc("latch as reset", ADDR_GPIO_E_OUTPUT_LATCH, 8'h06);
    rdc("dir as reset", ADDR_GPIO_E_DIRECTION, 8'h06);
    rdc("sample as reset", ADDR_GPIO_E_PIN_SAMPLE, 8'h06);
    fuse <= 1'b1;
    tick(5);
    chk("no pin reset", 0, rst_req);
    chk("e0 plain io", 1, e_oe[0]);
    rdc("latch kept", ADDR_GPIO_E_OUTPUT_LATCH, 8'h07);
    wr(ADDR_GPIO_E_DIRECTION, 8'h00);
    e_ed <= 3'h7;
    e_ev <= 3'h5;
    tick(5);
    chk("pin change", 3'h5, {pc26, pc25, pc24});
    wr(ADDR_GPIO_CONFIG, 8'h02);
    tick(5);
    chk("analog disable", 0, pc26);
    // second reset in mid-run: a written latch must clear again
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    rdc("latch after reset", ADDR_GPIO_B_OUTPUT_LATCH, 0);
    chk("b pull-up after reset", 0, b_pu);
    end_of_test();
  end
endmodule // tb
